// file: rtl/ppc_pkg.sv
// Package with register map, field positions and pin-mode codes for the pad configuration block
// Behaviour
// - Port-1 analog bits 7:4 set pins analog
// - Pin 1.3 mode from hall bit, direction
// - Drive bit selects high drive for PWM pins
// - Two bits give open-drain on pins 0.1, 0.0
// - Port-2 analog bits set pins analog
// - Port-3 analog bits 5:0 set pins analog
// - Port-3 bit 7 enables pin 1.1 pull-down
// - Port-3 bit 6 enables pin 0.1 pull-down
// - Ports 0-3 pull-up registers, bit per pin
// - Port-4 pull-ups per pin, bit 3 reserved
// - Analog pin loses digital, data reads zero
// - Pull-ups forced off on analog pins, except port-1 pins 1.3-1.5
// - Direction bit: 0 input, 1 output
package ppc_pkg;
  // Printed offsets are not word multiples, so they are indices; byte address is four times
  localparam logic [15:0] IDX_PORT1_ANALOG_AND_PAD_CTRL = 16'h4050;
  localparam logic [15:0] IDX_PORT2_ANALOG_ENABLE = 16'h4051;
  localparam logic [15:0] IDX_PORT3_ANALOG_AND_PULLDOWN = 16'h4052;
  localparam logic [15:0] IDX_PORT0_PULLUP_ENABLE = 16'h4053;
  localparam logic [15:0] IDX_PORT1_PULLUP_ENABLE = 16'h4054;
  localparam logic [15:0] IDX_PORT2_PULLUP_ENABLE = 16'h4055;
  localparam logic [15:0] IDX_PORT3_PULLUP_ENABLE = 16'h4056;
  localparam logic [15:0] IDX_PORT4_PULLUP_ENABLE = 16'h4057;
  localparam int NUM_REGS = 8;
  localparam logic [7:0] RESET_VAL = 8'h00;
  // Writable bits of the port-4 pull-up register; bit 3 reserved
  localparam logic [7:0] PORT4_PULLUP_ENABLE_MASK = 8'hf7;
  // Fields of the port-1 analog and pad control register
  localparam int HALL_BIAS_MODE_BIT_BIT = 3;
  localparam int PWM_HIGH_DRIVE_SELECT_BIT = 2;
  localparam int PIN01_OPEN_DRAIN_ENABLE_BIT = 1;
  localparam int PIN00_OPEN_DRAIN_ENABLE_BIT = 0;
  localparam int PORT1_ANALOG_AND_PAD_CTRL_LO = 4;
  // Fields of the port-3 analog register
  localparam int PIN11_PULLDOWN_ENABLE_BIT = 7;
  localparam int PIN01_PULLDOWN_ENABLE_BIT = 6;
  localparam int PORT3_ANALOG_AND_PULLDOWN_W = 6;
  localparam int PIN13 = 3;
  // Pin 1.3 mode, Gray order along input -> output -> enhanced -> analog
  typedef enum logic [1:0] {
    PPC_PIN_IN = 2'b00,
    PPC_PIN_OUT = 2'b01,
    PPC_PIN_ENH = 2'b11,
    PPC_PIN_ANA = 2'b10
  } ppc_pin_mode_e;
endpackage

// file: rtl/ppc_pin13_mode.sv
// Mode decoder for port 1 pin 3 with a registered mode output
`timescale 1ns/100ps
`default_nettype none
module ppc_pin13_mode (
  input wire logic ref_clk,
  input wire logic reset,
  input wire logic hall_bias_mode_bit,
  input wire logic dir_bit,
  output ppc_pkg::ppc_pin_mode_e mode_q
);
  ppc_pkg::ppc_pin_mode_e mode_d;

  // Two control bits map to one of four pad modes
  always_comb begin
    case ({hall_bias_mode_bit, dir_bit})
      2'b00: mode_d = ppc_pkg::PPC_PIN_IN;
      2'b01: mode_d = ppc_pkg::PPC_PIN_OUT;
      2'b10: mode_d = ppc_pkg::PPC_PIN_ANA;
      2'b11: mode_d = ppc_pkg::PPC_PIN_ENH;
      default: mode_d = ppc_pkg::PPC_PIN_IN;
    endcase
  end

  // Registered so pad controls never glitch during a write
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      mode_q <= ppc_pkg::PPC_PIN_IN;
    end else begin
      mode_q <= mode_d;
    end
  end
endmodule
`default_nettype wire

// file: rtl/ppc_regs.sv
// Pad configuration registers on APB with derived per-pin pad controls
//
// The APB register port was decided locally.
`timescale 1ns/100ps
`default_nettype none
module ppc_regs #(
  parameter int ADDR_W = 18
) (
  input wire logic ref_clk,
  input wire logic reset,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [7:0] port1_direction,
  input wire logic [7:0] port1_pin_in,
  input wire logic [7:0] port2_pin_in,
  input wire logic [7:0] port3_pin_in,
  output logic [7:0] port1_data_rd,
  output logic [7:0] port2_data_rd,
  output logic [7:0] port3_data_rd,
  output logic [7:0] port1_analog_mode,
  output logic [7:0] port2_analog_mode,
  output logic [7:0] port3_analog_mode,
  output logic [7:0] port1_digital_oe,
  output logic pin13_enhanced_drive,
  output logic pwm_high_drive_select,
  output logic pin00_open_drain_enable,
  output logic pin01_open_drain_enable,
  output logic pin11_pulldown_enable,
  output logic pin01_pulldown_enable,
  output logic [7:0] port0_pullup_en,
  output logic [7:0] port1_pullup_en,
  output logic [7:0] port2_pullup_en,
  output logic [7:0] port3_pullup_en,
  output logic [7:0] port4_pullup_en
);
  logic [7:0] regs_q [ppc_pkg::NUM_REGS];
  logic [7:0] regs_d [ppc_pkg::NUM_REGS];
  logic [31:0] prdata_d;
  logic [31:0] prdata_q;
  logic hit;
  logic [2:0] sel;
  logic [15:0] word_idx;
  logic access;
  ppc_pkg::ppc_pin_mode_e pin13_mode;

  // Word index is the byte address over four; low two bits ignored
  assign word_idx = 16'(paddr[ADDR_W-1:2]);
  assign access = psel && penable;

  // Address decode onto the eight consecutive indices
  always_comb begin
    hit = (word_idx >= ppc_pkg::IDX_PORT1_ANALOG_AND_PAD_CTRL) && (word_idx <= ppc_pkg::IDX_PORT4_PULLUP_ENABLE);
    sel = 3'(word_idx - ppc_pkg::IDX_PORT1_ANALOG_AND_PAD_CTRL);
  end

  // Register write; only byte lane 0 carries data, reserved bit masked
  always_comb begin
    for (int i = 0; i < ppc_pkg::NUM_REGS; i++) begin
      regs_d[i] = regs_q[i];
    end
    if (access && pwrite && hit && pstrb[0]) begin
      if (sel == 3'(ppc_pkg::IDX_PORT4_PULLUP_ENABLE - ppc_pkg::IDX_PORT1_ANALOG_AND_PAD_CTRL)) begin
        regs_d[sel] = pwdata[7:0] & ppc_pkg::PORT4_PULLUP_ENABLE_MASK;
      end else begin
        regs_d[sel] = pwdata[7:0];
      end
    end
  end

  // Read data; unmapped reads return zero with an error
  always_comb begin
    prdata_d = prdata_q;
    if (psel && !penable && !pwrite) begin
      prdata_d = hit ? {24'h000000, regs_q[sel]} : 32'h00000000;
    end
  end

  // Registers hold their value; asynchronous reset to zeros
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      for (int i = 0; i < ppc_pkg::NUM_REGS; i++) begin
        regs_q[i] <= ppc_pkg::RESET_VAL;
      end
      prdata_q <= 32'h00000000;
    end else begin
      for (int i = 0; i < ppc_pkg::NUM_REGS; i++) begin
        regs_q[i] <= regs_d[i];
      end
      prdata_q <= prdata_d;
    end
  end

  // Zero-wait slave: read data captured in setup, valid in the access phase
  assign pready = 1'b1;
  assign pslverr = access && !hit;
  assign prdata = prdata_q;

  ppc_pin13_mode u_pin13 (
    .ref_clk(ref_clk),
    .reset(reset),
    .hall_bias_mode_bit(regs_q[0][ppc_pkg::HALL_BIAS_MODE_BIT_BIT]),
    .dir_bit(port1_direction[ppc_pkg::PIN13]),
    .mode_q(pin13_mode)
  );

  // Per-pin analog select, digital gating and pull-up forcing
  for (genvar b = 0; b < 8; b++) begin : g_pin
    logic p1a;
    logic p2a;
    logic p3a;
    if (b >= ppc_pkg::PORT1_ANALOG_AND_PAD_CTRL_LO) begin : g_p1hi
      assign p1a = regs_q[0][b];
    end else if (b == ppc_pkg::PIN13) begin : g_p13
      assign p1a = (pin13_mode == ppc_pkg::PPC_PIN_ANA);
    end else begin : g_p1lo
      assign p1a = 1'b0;
    end
    assign p2a = regs_q[1][b];
    if (b < ppc_pkg::PORT3_ANALOG_AND_PULLDOWN_W) begin : g_p3lo
      assign p3a = regs_q[2][b];
    end else begin : g_p3hi
      assign p3a = 1'b0;
    end
    assign port1_analog_mode[b] = p1a;
    assign port2_analog_mode[b] = p2a;
    assign port3_analog_mode[b] = p3a;
    // Analog pins read zero; port-1 analog pins also drop their output driver
    assign port1_data_rd[b] = port1_pin_in[b] & ~p1a;
    assign port2_data_rd[b] = port2_pin_in[b] & ~p2a;
    assign port3_data_rd[b] = port3_pin_in[b] & ~p3a;
    assign port1_digital_oe[b] = port1_direction[b] & ~p1a;
    // Only pins 1.6 and 1.7 are forced; 1.3-1.5 keep their pull-up as documented
    if (b >= 6) begin : g_pu1f
      assign port1_pullup_en[b] = regs_q[4][b] & ~p1a;
    end else begin : g_pu1
      assign port1_pullup_en[b] = regs_q[4][b];
    end
    assign port2_pullup_en[b] = regs_q[5][b] & ~p2a;
    assign port3_pullup_en[b] = regs_q[6][b] & ~p3a;
  end

  assign pin13_enhanced_drive = (pin13_mode == ppc_pkg::PPC_PIN_ENH);
  assign pwm_high_drive_select = regs_q[0][ppc_pkg::PWM_HIGH_DRIVE_SELECT_BIT];
  assign pin00_open_drain_enable = regs_q[0][ppc_pkg::PIN00_OPEN_DRAIN_ENABLE_BIT];
  assign pin01_open_drain_enable = regs_q[0][ppc_pkg::PIN01_OPEN_DRAIN_ENABLE_BIT];
  // Pull-downs follow software; exclusivity with pull-ups is software's duty
  assign pin11_pulldown_enable = regs_q[2][ppc_pkg::PIN11_PULLDOWN_ENABLE_BIT];
  assign pin01_pulldown_enable = regs_q[2][ppc_pkg::PIN01_PULLDOWN_ENABLE_BIT];
  assign port0_pullup_en = regs_q[3];
  assign port4_pullup_en = regs_q[7];

  // Checks
  a_write_p2_analog: assert property (@(posedge ref_clk) disable iff (reset)
    access && pwrite && hit && pstrb[0] && sel == 3'd1 |=> port2_analog_mode == $past(pwdata[7:0]))
    else $error("port2 analog write not applied");
  a_p4_reserved: assert property (@(posedge ref_clk) disable iff (reset)
    !port4_pullup_en[3]) else $error("reserved pull-up bit set");
  a_analog_reads_zero: assert property (@(posedge ref_clk) disable iff (reset)
    (port2_analog_mode & port2_data_rd) == 8'h00) else $error("analog pin read nonzero");
  a_analog_pullup_off: assert property (@(posedge ref_clk) disable iff (reset)
    (port3_analog_mode & port3_pullup_en) == 8'h00) else $error("pull-up on analog pin");
  a_pin13_analog: assert property (@(posedge ref_clk) disable iff (reset)
    regs_q[0][3] && !port1_direction[3] ##1 regs_q[0][3] && !port1_direction[3]
    |-> port1_analog_mode[3]) else $error("pin 1.3 not analog");
  a_pin13_enh: assert property (@(posedge ref_clk) disable iff (reset)
    regs_q[0][ppc_pkg::HALL_BIAS_MODE_BIT_BIT] && port1_direction[ppc_pkg::PIN13] |=> pin13_enhanced_drive)
    else $error("pin 1.3 enhanced drive missing");
  // Enhanced drive and analog mode of pin 1.3 exclude each other
  a_pin13_excl: assert property (@(posedge ref_clk) disable iff (reset)
    !(pin13_enhanced_drive && port1_analog_mode[ppc_pkg::PIN13]))
    else $error("pin 1.3 in two modes");
  // Pin 1.3 without hall-bias bit never goes analog one cycle later
  a_pin13_digital: assert property (@(posedge ref_clk) disable iff (reset)
    !regs_q[0][ppc_pkg::HALL_BIAS_MODE_BIT_BIT] |=> !port1_analog_mode[ppc_pkg::PIN13])
    else $error("pin 1.3 analog without mode bit");
  // Drive-strength output mirrors its register bit
  a_drive_sel: assert property (@(posedge ref_clk) disable iff (reset)
    pwm_high_drive_select == regs_q[0][ppc_pkg::PWM_HIGH_DRIVE_SELECT_BIT])
    else $error("drive select mismatch");
  // Open-drain outputs mirror their register bits
  a_open_drain: assert property (@(posedge ref_clk) disable iff (reset)
    {pin01_open_drain_enable, pin00_open_drain_enable} == regs_q[0][1:0])
    else $error("open-drain mismatch");
  // Port-3 analog enables only on pins 0 to 5
  a_p3_analog: assert property (@(posedge ref_clk) disable iff (reset)
    port3_analog_mode == {2'b00, regs_q[2][5:0]})
    else $error("port3 analog mismatch");
  // Pin 0.1 pull-down mirrors bit six
  a_pulldown_p01: assert property (@(posedge ref_clk) disable iff (reset)
    pin01_pulldown_enable == regs_q[2][ppc_pkg::PIN01_PULLDOWN_ENABLE_BIT])
    else $error("pin 0.1 pull-down mismatch");
  // Port-0 pull-ups are never forced
  a_p0_pullups: assert property (@(posedge ref_clk) disable iff (reset)
    port0_pullup_en == regs_q[3])
    else $error("port0 pull-up mismatch");
  // Port-2 pull-ups drop on analog pins
  a_p2_pullup_off: assert property (@(posedge ref_clk) disable iff (reset)
    (port2_analog_mode & port2_pullup_en) == 8'h00)
    else $error("port2 pull-up on analog pin");
  // Port-1 analog pins drop their output driver
  a_port1_direction_off: assert property (@(posedge ref_clk) disable iff (reset)
    (port1_analog_mode & port1_digital_oe) == 8'h00)
    else $error("output enabled on analog pin");
  // Port-3 analog pins read zero
  a_p3_reads_zero: assert property (@(posedge ref_clk) disable iff (reset)
    (port3_analog_mode & port3_data_rd) == 8'h00)
    else $error("port3 analog pin read nonzero");
  a_p1_high_analog: assert property (@(posedge ref_clk) disable iff (reset)
    port1_analog_mode[7:4] == regs_q[0][7:4]) else $error("port1 analog mismatch");
  a_dir_oe: assert property (@(posedge ref_clk) disable iff (reset)
    !port1_analog_mode[0] |-> port1_digital_oe[0] == port1_direction[0])
    else $error("direction not honoured");
  a_pulldown_p11: assert property (@(posedge ref_clk) disable iff (reset)
    access && pwrite && pstrb[0] && hit && sel == 3'd2 |=> pin11_pulldown_enable == $past(pwdata[7]))
    else $error("pull-down write lost");
  c_write: cover property (@(posedge ref_clk) access && pwrite && hit);
  c_read: cover property (@(posedge ref_clk) access && !pwrite && hit);
  c_unmapped: cover property (@(posedge ref_clk) pslverr);
  c_enh: cover property (@(posedge ref_clk) pin13_enhanced_drive);
endmodule
`default_nettype wire

// file: bench/ppc_pad_model.sv
// Model of the external circuitry on the port 1 to 3 pins
`timescale 1ns/100ps
`default_nettype none
module ppc_pad_model (
  input wire logic ref_clk,
  input wire logic [23:0] ext_val,
  input wire logic [23:0] ext_drv,
  input wire logic [23:0] pull_en,
  output logic [23:0] pin_lvl
);
  logic flip_q;
  initial flip_q = 1'b0;
  // An undriven pin without pull-up wanders, so a stale level never passes
  always @(posedge ref_clk) begin
    flip_q <= ~flip_q;
  end
  // A driven pin shows the level; an undriven pin follows its pull-up
  always_comb begin
    for (int i = 0; i < 24; i++) begin
      pin_lvl[i] = ext_drv[i] ? ext_val[i] : (pull_en[i] | flip_q);
    end
  end
endmodule
`default_nettype wire

// file: bench/port_pad_config_regs_tb_top.sv
// Register and pad-control testbench for the pad configuration block
`timescale 1ns/100ps
`default_nettype none
module port_pad_config_regs_tb_top;
  logic ref_clk, reset, psel, penable, pwrite, pready, pslverr, perr;
  logic pin13_enhanced_drive, pwm_high_drive_select;
  logic pin00_open_drain_enable, pin01_open_drain_enable;
  logic pin11_pulldown_enable, pin01_pulldown_enable;
  logic [17:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [3:0] pstrb;
  logic [7:0] port1_direction, port1_data_rd, port2_data_rd, port3_data_rd;
  logic [7:0] port1_analog_mode, port2_analog_mode, port3_analog_mode, port1_digital_oe;
  logic [7:0] port0_pullup_en, port1_pullup_en, port2_pullup_en;
  logic [7:0] port3_pullup_en, port4_pullup_en;
  logic [23:0] pin_lvl, ext_val;
  int mismatches = 0;
  int checks_done = 0;
  ppc_regs ppc_regs_inst (.ref_clk, .reset, .psel, .penable, .pwrite, .paddr, .pwdata,
    .pstrb, .prdata, .pready, .pslverr, .port1_direction, .port1_pin_in(pin_lvl[7:0]),
    .port2_pin_in(pin_lvl[15:8]), .port3_pin_in(pin_lvl[23:16]), .port1_data_rd,
    .port2_data_rd, .port3_data_rd, .port1_analog_mode, .port2_analog_mode,
    .port3_analog_mode, .port1_digital_oe, .pin13_enhanced_drive, .pwm_high_drive_select,
    .pin00_open_drain_enable, .pin01_open_drain_enable, .pin11_pulldown_enable,
    .pin01_pulldown_enable, .port0_pullup_en, .port1_pullup_en, .port2_pullup_en,
    .port3_pullup_en, .port4_pullup_en);
  ppc_pad_model ppc_pad_model_inst (.ref_clk, .ext_val, .ext_drv(24'hffffff),
    .pull_en({port3_pullup_en, port2_pullup_en, port1_pullup_en}), .pin_lvl);
  // Clock at 25 MHz
  initial begin
    ref_clk = 1'b0;
    forever #20 ref_clk = ~ref_clk;
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      mismatches++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // One APB transfer; request held until pready is seen high
  task automatic apb(input logic w, input logic [15:0] ix, input logic [7:0] d,
                     input logic s);
    @(posedge ref_clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= {ix, 2'b00};
    pwdata <= {24'h0, d};
    pstrb <= {3'b0, s};
    @(posedge ref_clk);
    penable <= 1'b1;
    @(posedge ref_clk);
    while (pready !== 1'b1) @(posedge ref_clk);
    rd = prdata;
    perr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic results();
    $display("checks %0d mismatches %0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  // Watchdog sized well beyond the about 120 cycles of the sequence
  initial begin
    repeat (3000) @(posedge ref_clk);
    mismatches++;
    results();
  end
  initial begin
    {psel, penable, pwrite, paddr, pwdata, pstrb} = '0;
    port1_direction = 8'h00;
    ext_val = 24'hffffff;
    reset = 1'b1;
    repeat (3) @(posedge ref_clk);
    reset <= 1'b0;
    for (int i = 0; i < 8; i++) begin
      apb(1'b0, ppc_pkg::IDX_PORT1_ANALOG_AND_PAD_CTRL + 16'(i), 8'h00, 1'b0);
      chk(rd, 32'h0);
    end
    // Pull-up bit 1 stays clear so later pull-downs never clash
    for (int i = 0; i < 8; i++) begin
      apb(1'b1, ppc_pkg::IDX_PORT1_ANALOG_AND_PAD_CTRL + 16'(i), 8'hfd, 1'b1);
      apb(1'b0, ppc_pkg::IDX_PORT1_ANALOG_AND_PAD_CTRL + 16'(i), 8'h00, 1'b0);
      chk(rd, (i == 7) ? 32'hf5 : 32'hfd);
    end
    chk({port0_pullup_en, port4_pullup_en}, 16'hfdf5);
    port1_direction <= 8'hff;
    apb(1'b1, ppc_pkg::IDX_PORT1_ANALOG_AND_PAD_CTRL, 8'hf7, 1'b1);
    repeat (3) @(posedge ref_clk);
    chk({port1_analog_mode, port1_digital_oe, port1_data_rd}, 24'hf00f0f);
    chk({pwm_high_drive_select, pin01_open_drain_enable, pin00_open_drain_enable}, 3'h7);
    chk(port1_pullup_en, 32'h3d);
    apb(1'b1, ppc_pkg::IDX_PORT2_ANALOG_ENABLE, 8'ha5, 1'b1);
    apb(1'b1, ppc_pkg::IDX_PORT2_ANALOG_ENABLE, 8'h00, 1'b0);
    apb(1'b0, ppc_pkg::IDX_PORT2_ANALOG_ENABLE, 8'h00, 1'b0);
    chk(rd, 32'ha5);
    chk({port2_analog_mode, port2_pullup_en, port2_data_rd}, 24'ha5585a);
    apb(1'b1, ppc_pkg::IDX_PORT3_ANALOG_AND_PULLDOWN, 8'hff, 1'b1);
    // The write lands at the edge the task returns on; let it settle
    @(posedge ref_clk);
    chk({port3_analog_mode, port3_pullup_en, port3_data_rd}, 24'h3fc0c0);
    chk({pin11_pulldown_enable, pin01_pulldown_enable}, 2'h3);
    // All four direction and hall-bias pairings of pin 1.3
    for (int k = 0; k < 4; k++) begin
      port1_direction <= {4'h0, k[0], 3'h0};
      apb(1'b1, ppc_pkg::IDX_PORT1_ANALOG_AND_PAD_CTRL, {4'h0, k[1], 3'h0}, 1'b1);
      repeat (3) @(posedge ref_clk);
      chk({port1_analog_mode[3], pin13_enhanced_drive, port1_digital_oe[3]},
          {k[1] & ~k[0], k[1] & k[0], k[0]});
    end
    apb(1'b0, 16'h4058, 8'h00, 1'b0);
    chk(rd, 32'h0);
    chk({31'h0, perr}, 32'h1);
    results();
  end
endmodule
`default_nettype wire
